/* hdl/sccp_pkg.sv */
// constants, states and the command carrier of the serial command front end
// assumes one clock domain shared by the character source, interpreter and transmitter
package sccp_pkg;

  localparam logic [7:0] SCCP_ACK       = 8'h06;
  localparam logic [7:0] SCCP_NAK       = 8'h15;
  localparam logic [7:0] SCCP_CR        = 8'h0d;
  localparam logic [7:0] SCCP_LF        = 8'h0a;
  localparam logic [7:0] SCCP_BCAST     = 8'h2a;
  localparam logic [7:0] SCCP_CKS_TOP   = 8'h80;
  localparam logic [7:0] SCCP_SUM_RST   = 8'h00;
  localparam logic [6:0] SCCP_SUM7_OK   = 7'h00;
  localparam logic [7:0] SCCP_LOWER_A   = 8'h61;
  localparam logic [7:0] SCCP_LOWER_Z   = 8'h7a;
  localparam logic [7:0] SCCP_CASE_BIT  = 8'h20;
  localparam logic [7:0] SCCP_CH_P      = 8'h50;
  localparam logic [7:0] SCCP_CH_Y      = 8'h59;
  localparam logic [7:0] SCCP_CH_EQ     = 8'h3d;
  localparam logic [7:0] SCCP_CH_ZERO   = 8'h30;

  localparam int         SCCP_DEPTH     = 16;
  localparam int         SCCP_LEN_W     = 5;
  localparam logic [SCCP_LEN_W-1:0] SCCP_LEN_FULL = 5'h10;
  localparam logic [SCCP_LEN_W-1:0] SCCP_LEN_ZERO = 5'h00;
  localparam logic [SCCP_LEN_W-1:0] SCCP_LEN_ONE  = 5'h01;
  localparam logic [SCCP_LEN_W-1:0] SCCP_LEN_PYOFF = 5'h04;

  typedef struct packed {
    logic                              broadcast;
    logic [SCCP_LEN_W-1:0]             len;
    logic [SCCP_DEPTH-1:0][7:0]        text;
  } sccp_cmd_t;

  typedef enum logic [2:0] {
    RX_START = 3'b001,
    RX_BODY  = 3'b010,
    RX_SPARE = 3'b100
  } sccp_rx_state_t;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_RESP = 5'b00010,
    TX_CKS  = 5'b00100,
    TX_CR   = 5'b01000,
    TX_LF   = 5'b10000
  } sccp_tx_state_t;

endpackage

/* hdl/sccp_top.sv */
// character front end: checksum check, party addressing, ack/nak and reply checksum
// assumes rx, response and tx streams come from logic on i_clock
`timescale 1ns/100ps
module sccp_top
  import sccp_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_rst_b,
  input  wire logic              i_checksum_enable,
  input  wire logic [7:0]        i_unit_name,
  input  wire logic              i_rx_valid,
  input  wire logic [7:0]        i_rx_data,
  output logic                   o_rx_ready,
  output logic                   o_cmd_valid,
  output sccp_pkg::sccp_cmd_t    o_cmd,
  output logic                   o_cks_error,
  input  wire logic              i_resp_valid,
  input  wire logic [7:0]        i_resp_data,
  input  wire logic              i_resp_last,
  output logic                   o_resp_ready,
  output logic                   o_tx_valid,
  output logic [7:0]             o_tx_data,
  input  wire logic              i_tx_ready,
  output logic                   o_party_flag,
  output logic                   o_reply_allowed
);
  import sccp_pkg::*;

  function automatic logic [7:0] upcase(input logic [7:0] c);
    upcase = ((c >= SCCP_LOWER_A) && (c <= SCCP_LOWER_Z)) ? (c & ~SCCP_CASE_BIT) : c;
  endfunction

  function automatic logic is_party_off(input logic [SCCP_DEPTH-1:0][7:0] t,
                                        input logic [SCCP_LEN_W-1:0]     n);
    is_party_off = (n == SCCP_LEN_PYOFF) && (t[0] == SCCP_CH_P) && (t[1] == SCCP_CH_Y)
                   && (t[2] == SCCP_CH_EQ) && (t[3] == SCCP_CH_ZERO);
  endfunction

  sccp_rx_state_t             rx_state_r,  rx_state_nxt;
  sccp_tx_state_t             tx_state_r,  tx_state_nxt;
  logic [7:0]                 rx_sum_r,    rx_sum_nxt;
  logic [SCCP_LEN_W-1:0]      rx_len_r,    rx_len_nxt;
  logic [SCCP_DEPTH-1:0][7:0] rx_buf_r,    rx_buf_nxt;
  logic                       rx_ovf_r,    rx_ovf_nxt;
  logic                       addr_r,      addr_nxt;
  logic                       bcast_r,     bcast_nxt;
  logic                       party_r,     party_nxt;
  logic                       reply_ok_r,  reply_ok_nxt;
  logic                       pend_r,      pend_nxt;
  logic [7:0]                 pend_byte_r, pend_byte_nxt;
  logic [7:0]                 tx_sum_r,    tx_sum_nxt;
  logic                       tx_valid_r,  tx_valid_nxt;
  logic [7:0]                 tx_data_r,   tx_data_nxt;
  logic                       rx_ready_r,  rx_ready_nxt;
  logic                       resp_rdy_r,  resp_rdy_nxt;
  logic                       cmd_valid_r, cmd_valid_nxt;
  sccp_cmd_t                  cmd_r,       cmd_nxt;
  logic                       cks_err_r,   cks_err_nxt;

  logic                       rx_take;
  logic                       resp_take;
  logic                       tx_free;
  logic                       is_term;
  logic                       do_store;
  logic                       sum_ok;
  logic [7:0]                 rx_sum_new;
  logic [7:0]                 tx_sum_new;
  logic [SCCP_LEN_W-1:0]      body_len;

  always_comb
  begin
    rx_state_nxt  = rx_state_r;
    tx_state_nxt  = tx_state_r;
    rx_sum_nxt    = rx_sum_r;
    rx_len_nxt    = rx_len_r;
    rx_buf_nxt    = rx_buf_r;
    rx_ovf_nxt    = rx_ovf_r;
    addr_nxt      = addr_r;
    bcast_nxt     = bcast_r;
    party_nxt     = party_r;
    reply_ok_nxt  = reply_ok_r;
    pend_nxt      = pend_r;
    pend_byte_nxt = pend_byte_r;
    tx_sum_nxt    = tx_sum_r;
    tx_data_nxt   = tx_data_r;
    cmd_nxt       = cmd_r;
    cmd_valid_nxt = 1'b0;
    cks_err_nxt   = 1'b0;
    do_store      = 1'b0;
    rx_take       = i_rx_valid && rx_ready_r;
    resp_take     = i_resp_valid && resp_rdy_r;
    tx_free       = !tx_valid_r || i_tx_ready;
    tx_valid_nxt  = tx_valid_r && !i_tx_ready;
    rx_sum_new    = rx_sum_r + i_rx_data;
    tx_sum_new    = tx_sum_r + i_resp_data;
    is_term       = party_r ? (i_rx_data == SCCP_LF) : (i_rx_data == SCCP_CR);
    sum_ok        = !i_checksum_enable
                    || ((rx_sum_r[6:0] == SCCP_SUM7_OK) && (rx_len_r != SCCP_LEN_ZERO));
    body_len      = i_checksum_enable ? (rx_len_r - SCCP_LEN_ONE) : rx_len_r;

    // reply path: pending answer, then checksummed response bytes
    unique case (tx_state_r)
      TX_IDLE:
      begin
        tx_sum_nxt = SCCP_SUM_RST;
        if (resp_take)
        begin
          tx_sum_nxt = SCCP_SUM_RST + i_resp_data;
          if (reply_ok_r)
          begin
            tx_valid_nxt = 1'b1;
            tx_data_nxt  = i_resp_data;
          end
          tx_state_nxt = !i_resp_last ? TX_RESP
                         : (!reply_ok_r ? TX_IDLE : (i_checksum_enable ? TX_CKS : TX_CR));
        end
        else if (pend_r && tx_free)
        begin
          tx_valid_nxt = 1'b1;
          tx_data_nxt  = pend_byte_r;
          pend_nxt     = 1'b0;
          if (pend_byte_r == SCCP_CR)
            tx_state_nxt = TX_LF;
        end
      end
      TX_RESP:
      begin
        if (resp_take)
        begin
          tx_sum_nxt = tx_sum_new;
          if (reply_ok_r)
          begin
            tx_valid_nxt = 1'b1;
            tx_data_nxt  = i_resp_data;
          end
          if (i_resp_last)
            tx_state_nxt = !reply_ok_r ? TX_IDLE : (i_checksum_enable ? TX_CKS : TX_CR);
        end
      end
      TX_CKS:
      begin
        if (tx_free)
        begin
          tx_valid_nxt = 1'b1;
          tx_data_nxt  = ((~tx_sum_r) + 8'h01) | SCCP_CKS_TOP;
          tx_state_nxt = TX_CR;
        end
      end
      TX_CR:
      begin
        if (tx_free)
        begin
          tx_valid_nxt = 1'b1;
          tx_data_nxt  = SCCP_CR;
          tx_state_nxt = TX_LF;
        end
      end
      TX_LF:
      begin
        if (tx_free)
        begin
          tx_valid_nxt = 1'b1;
          tx_data_nxt  = SCCP_LF;
          tx_state_nxt = TX_IDLE;
        end
      end
      default:
      begin
        tx_state_nxt = TX_IDLE;
      end
    endcase

    // receive path: prefix, body capture, terminator decision
    if (rx_take)
    begin
      unique case (rx_state_r)
        RX_START:
        begin
          if (i_rx_data == SCCP_LF)
          begin
            party_nxt = 1'b1;
          end
          else if (!is_term)
          begin
            rx_sum_nxt   = rx_sum_new;
            rx_state_nxt = RX_BODY;
            if (party_r)
            begin
              addr_nxt  = (i_rx_data == i_unit_name);
              bcast_nxt = (i_rx_data == SCCP_BCAST);
            end
            else
            begin
              addr_nxt  = 1'b1;
              bcast_nxt = 1'b0;
              do_store  = 1'b1;
            end
          end
        end
        RX_BODY:
        begin
          if (is_term)
          begin
            rx_state_nxt = RX_START;
            rx_sum_nxt   = SCCP_SUM_RST;
            rx_len_nxt   = SCCP_LEN_ZERO;
            rx_ovf_nxt   = 1'b0;
            if (addr_r || bcast_r)
            begin
              if (!sum_ok || rx_ovf_r)
              begin
                cks_err_nxt = 1'b1;
                if (i_checksum_enable)
                begin
                  pend_nxt      = 1'b1;
                  pend_byte_nxt = SCCP_NAK;
                end
              end
              else
              begin
                cmd_valid_nxt     = 1'b1;
                cmd_nxt.text      = rx_buf_r;
                cmd_nxt.len       = body_len;
                cmd_nxt.broadcast = bcast_r;
                reply_ok_nxt      = !bcast_r;
                if (is_party_off(rx_buf_r, body_len))
                  party_nxt = 1'b0;
                pend_nxt      = 1'b1;
                pend_byte_nxt = i_checksum_enable ? SCCP_ACK : SCCP_CR;
              end
            end
          end
          else
          begin
            rx_sum_nxt = rx_sum_new;
            do_store   = 1'b1;
          end
        end
        default:
        begin
          rx_state_nxt = RX_START;
        end
      endcase
    end

    if (do_store)
    begin
      if (rx_len_r == SCCP_LEN_FULL)
        rx_ovf_nxt = 1'b1;
      else
      begin
        rx_buf_nxt[rx_len_r] = upcase(i_rx_data);
        rx_len_nxt           = rx_len_r + SCCP_LEN_ONE;
      end
    end

    rx_ready_nxt = (tx_state_nxt == TX_IDLE) && !pend_nxt;
    resp_rdy_nxt = ((tx_state_nxt == TX_RESP) || ((tx_state_nxt == TX_IDLE) && !pend_nxt))
                   && !tx_valid_nxt;
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_state_r  <= RX_START;
      tx_state_r  <= TX_IDLE;
      rx_sum_r    <= SCCP_SUM_RST;
      rx_len_r    <= SCCP_LEN_ZERO;
      rx_buf_r    <= '0;
      rx_ovf_r    <= 1'b0;
      addr_r      <= 1'b0;
      bcast_r     <= 1'b0;
      party_r     <= 1'b0;
      reply_ok_r  <= 1'b1;
      pend_r      <= 1'b0;
      pend_byte_r <= SCCP_SUM_RST;
      tx_sum_r    <= SCCP_SUM_RST;
      tx_valid_r  <= 1'b0;
      tx_data_r   <= SCCP_SUM_RST;
      rx_ready_r  <= 1'b0;
      resp_rdy_r  <= 1'b0;
      cmd_valid_r <= 1'b0;
      cmd_r       <= '0;
      cks_err_r   <= 1'b0;
    end
    else
    begin
      rx_state_r  <= rx_state_nxt;
      tx_state_r  <= tx_state_nxt;
      rx_sum_r    <= rx_sum_nxt;
      rx_len_r    <= rx_len_nxt;
      rx_buf_r    <= rx_buf_nxt;
      rx_ovf_r    <= rx_ovf_nxt;
      addr_r      <= addr_nxt;
      bcast_r     <= bcast_nxt;
      party_r     <= party_nxt;
      reply_ok_r  <= reply_ok_nxt;
      pend_r      <= pend_nxt;
      pend_byte_r <= pend_byte_nxt;
      tx_sum_r    <= tx_sum_nxt;
      tx_valid_r  <= tx_valid_nxt;
      tx_data_r   <= tx_data_nxt;
      rx_ready_r  <= rx_ready_nxt;
      resp_rdy_r  <= resp_rdy_nxt;
      cmd_valid_r <= cmd_valid_nxt;
      cmd_r       <= cmd_nxt;
      cks_err_r   <= cks_err_nxt;
    end
  end

  assign o_rx_ready      = rx_ready_r;
  assign o_cmd_valid     = cmd_valid_r;
  assign o_cmd           = cmd_r;
  assign o_cks_error     = cks_err_r;
  assign o_resp_ready    = resp_rdy_r;
  assign o_tx_valid      = tx_valid_r;
  assign o_tx_data       = tx_data_r;
  assign o_party_flag    = party_r;
  assign o_reply_allowed = reply_ok_r;

endmodule

/* testbench/sccp_top_sva.sv */
// concurrent checks on the command front end ports
// assumes single clock i_clock and async active-low i_rst_b
`timescale 1ns/100ps
module sccp_top_sva
  import sccp_pkg::*;
(
  input wire logic                i_clock,
  input wire logic                i_rst_b,
  input wire logic                i_checksum_enable,
  input wire logic                o_rx_ready,
  input wire logic                o_cmd_valid,
  input wire sccp_pkg::sccp_cmd_t o_cmd,
  input wire logic                o_cks_error,
  input wire logic                o_tx_valid,
  input wire logic [7:0]          o_tx_data,
  input wire logic                i_tx_ready,
  input wire logic                o_party_flag,
  input wire logic                o_reply_allowed
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  sequence ack_out_s;
    ##[1:20] (o_tx_valid && o_tx_data == SCCP_ACK);
  endsequence
  sequence nak_out_s;
    ##[1:20] (o_tx_valid && o_tx_data == SCCP_NAK);
  endsequence
  wire leave_cmd = o_cmd.len == SCCP_LEN_PYOFF && o_cmd.text[0] == SCCP_CH_P
    && o_cmd.text[1] == SCCP_CH_Y && o_cmd.text[2] == SCCP_CH_EQ
    && o_cmd.text[3] == SCCP_CH_ZERO;
  verdict_excl_a: assert property (!(o_cmd_valid && o_cks_error))
    else $error("command accepted and rejected together");
  verdict_pulse_a: assert property ((o_cmd_valid || o_cks_error)
    |=> !(o_cmd_valid || o_cks_error)) else $error("verdict pulse too long");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready
    |=> o_tx_valid && $stable(o_tx_data)) else $error("tx byte dropped");
  ack_code_a: assert property (o_cmd_valid && i_checksum_enable
    |-> ack_out_s) else $error("no ack after accepted command");
  nak_code_a: assert property (o_cks_error && i_checksum_enable
    |-> nak_out_s) else $error("no nak after rejected command");
  rx_busy_a: assert property (o_cmd_valid |-> !o_rx_ready)
    else $error("rx ready while answer pending");
  party_leave_a: assert property (o_cmd_valid && leave_cmd
    |-> !o_party_flag) else $error("party mode not left");
  cmd_stable_a: assert property (!$stable(o_cmd) |-> o_cmd_valid)
    else $error("command changed without pulse");
  reply_drop_a: assert property (o_cmd_valid && o_cmd.broadcast
    |-> !o_reply_allowed) else $error("reply allowed after broadcast");
endmodule
bind sccp_top sccp_top_sva i_sva (.i_clock(i_clock), .i_rst_b(i_rst_b),
  .i_checksum_enable(i_checksum_enable), .o_rx_ready(o_rx_ready),
  .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .o_cks_error(o_cks_error),
  .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready),
  .o_party_flag(o_party_flag), .o_reply_allowed(o_reply_allowed));

/* testbench/sccp_host_model.sv */
// host side of the serial link: takes device bytes, may stall
// assumes bench reads got[] and cnt hierarchically
`timescale 1ns/100ps
module sccp_host_model (
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  input  wire logic       i_slow,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready
);
  logic [7:0] got [0:31];
  int         cnt;
  // slow host takes a byte every other cycle
  always @(negedge i_clock or negedge i_rst_b)
    if (!i_rst_b)
      o_tx_ready <= 1'b0;
    else
      o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
  // replies are only logged, never acknowledged
  always @(posedge i_clock or negedge i_rst_b)
    if (!i_rst_b)
      cnt <= 0;
    else if (i_tx_valid && o_tx_ready)
    begin
      got[cnt[4:0]] <= i_tx_data;
      cnt <= cnt + 1;
    end
endmodule

/* testbench/sccp_top_tb.sv */
// self-checking bench for the command front end
// assumes host model on the tx side, bench drives rx and reply streams
`timescale 1ns/100ps
module sccp_top_tb;
  import sccp_pkg::*;
  logic clk, rst_b, cke, rxv, rspv, rspl, slow, txv, txr;
  logic [7:0] rxd, rspd, txd, uname;
  logic rxr, cmdv, ckerr, rspr, party, rpl;
  sccp_cmd_t cmd;
  int errors, comparisons, ncmd, nerr, ix;
  sccp_top i_dut (.i_clock(clk), .i_rst_b(rst_b), .i_checksum_enable(cke),
    .i_unit_name(uname), .i_rx_valid(rxv), .i_rx_data(rxd), .o_rx_ready(rxr),
    .o_cmd_valid(cmdv), .o_cmd(cmd), .o_cks_error(ckerr), .i_resp_valid(rspv),
    .i_resp_data(rspd), .i_resp_last(rspl), .o_resp_ready(rspr),
    .o_tx_valid(txv), .o_tx_data(txd), .i_tx_ready(txr),
    .o_party_flag(party), .o_reply_allowed(rpl));
  sccp_host_model i_host (.i_clock(clk), .i_rst_b(rst_b), .i_slow(slow),
    .i_tx_valid(txv), .i_tx_data(txd), .o_tx_ready(txr));
  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(negedge clk)
  begin
    if (cmdv === 1'b1) ncmd++;
    if (ckerr === 1'b1) nerr++;
  end
  task end_of_test;
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task put(input logic [7:0] b);
    int n;
    rxv = 1;
    rxd = b;
    for (n = 0; n < 200 && rxr !== 1'b1; n++) @(negedge clk);
    if (rxr !== 1'b1) errors++;
    @(negedge clk);
  endtask
  // bad: corrupt the checksum character
  task send(input logic [63:0] s, input int n, input logic ck, input logic bad,
            input logic [7:0] term);
    logic [7:0] sum;
    logic [7:0] b;
    sum = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      b = s[8*(n-1-i)+:8];
      sum = sum + b;
      put(b);
    end
    if (ck) put(((~sum) + 8'h01 | 8'h80) ^ {7'h00, bad});
    put(term);
    rxv = 0;
    repeat (3) @(negedge clk);
  endtask
  task txq(input logic [7:0] exp);
    for (int n = 0; n < 100 && i_host.cnt <= ix; n++) @(negedge clk);
    check(i_host.got[ix], exp);
    ix++;
  endtask
  task resp(input logic [7:0] b);
    int n;
    rspv = 1;
    rspd = b;
    rspl = 1;
    for (n = 0; n < 100 && rspr !== 1'b1; n++) @(negedge clk);
    if (rspr !== 1'b1) errors++;
    @(negedge clk);
    rspv = 0;
  endtask
  task t_plain;
    send("a", 1, 0, 0, SCCP_CR);
    check(ncmd, 1);
    check(cmd.len, 1);
    check(cmd.text[0], 8'h41);
    txq(SCCP_CR);
    txq(SCCP_LF);
  endtask
  task t_cks;
    cke = 1;
    slow = 1;
    send("mR 1", 4, 1, 0, SCCP_CR);
    check(cmd.len, 4);
    check(cmd.text[0], 8'h4d);
    txq(SCCP_ACK);
    slow = 0;
    send("mR 1", 4, 1, 1, SCCP_CR);
    check(ncmd, 2);
    check(nerr, 1);
    txq(SCCP_NAK);
  endtask
  task t_party;
    put(SCCP_LF);
    rxv = 0;
    repeat (3) @(negedge clk);
    check(party, 1);
    send("bX", 2, 1, 0, SCCP_LF);
    check(ncmd, 2);
    check(i_host.cnt, ix);
    send("BPR", 3, 1, 0, SCCP_LF);
    check(cmd.len, 2);
    check(cmd.broadcast, 0);
    txq(SCCP_ACK);
    resp(8'h31);
    txq(8'h31);
    txq(8'hcf);
    txq(SCCP_CR);
    txq(SCCP_LF);
  endtask
  task t_bcast;
    send("*py=0", 5, 1, 0, SCCP_LF);
    check(ncmd, 4);
    check(cmd.broadcast, 1);
    check(party, 0);
    check(rpl, 0);
    txq(SCCP_ACK);
    resp(8'h31);
    repeat (8) @(negedge clk);
    check(i_host.cnt, ix);
  endtask
  // overlong line is refused with a nak
  task t_ovf;
    for (int i = 0; i < 17; i++) put(8'h61);
    put(SCCP_CR);
    rxv = 0;
    repeat (3) @(negedge clk);
    check(nerr, 2);
    check(ncmd, 4);
    txq(SCCP_NAK);
  endtask
  initial
  begin
    {rst_b, cke, rxv, rspv, rspl, slow} = 0;
    {rxd, rspd} = 0;
    uname = 8'h42;
    {errors, comparisons, ncmd, nerr, ix} = 0;
    repeat (20) @(negedge clk);
    rst_b = 1;
    repeat (2) @(negedge clk);
    t_plain;
    t_cks;
    t_party;
    t_bcast;
    t_ovf;
    end_of_test;
  end
  initial
  begin
    #2000000;
    errors++;
    end_of_test;
  end
endmodule
